// ==== hdl/du_uart.sv ====
// du_uart: one serial port with a double buffered transmitter, a
// receiver with break, framing and overrun flags, and four modes.
// assumes: timer overflow inputs are one-cycle pulses on sys_clk; the
// receive data pin is asynchronous and is also driven in mode 0.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
// Function
// - separate transmit and receive interrupt outputs
// - holding byte follows stop bit with no gap
// - break status bit independent of reception
// - overrun flag marks a lost character
// - modes 0,2 fixed rate; 1,3 timer rate
// - timer 1 default; timer 2 per direction
// - buffer write loads transmit, read returns receive
// - mode 0 shifts eight bits, osc/16 clock
// - mode 1 ten-bit frame, stop to rx_ninth_bit
// - mode 2 eleven bits at osc/32
// - mode 3 like mode 2, timer rate
// - any buffer write starts a transmission; here a write with a byte already held replaces that byte
// - mode 0 receives when flag clear, enabled
// - modes 1-3 receive on start bit if enabled
// - control register holds mode, ninth bits, flags
// - tx done sets at end of each byte
// - tx done sets on write while idle
// - transmit ninth bit sampled when shifted out
// - bit timing runs at sixteen times baud
// - framing flag on bad stop, sticky
// - break flag on all-zero character, sticky
// - overrun flag when rx complete still set
module du_uart (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic serial_in_pin,
    output logic serial_in_pin_out,
    output logic serial_in_pin_oe,
    output logic serial_out_pin,
    output logic tx_irq,
    output logic rx_irq
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0] mode_r;
    logic ren_r, tb8_r, rb8_r, ti_r, ri_r;
    logic fe_r, br_r, oe_r, stint_r;
    logic rx_sel_r, tx_sel_r;
    logic div_r;
    logic sync1_r, sync2_r;
    du_pkg::du_state_t tx_st_r, rx_st_r;
    logic [3:0] tx_idx_r, rx_idx_r;
    logic [7:0] tx_byte_r, hold_r, rx_sh_r, rx_buf_r;
    logic hold_full_r, rx_nine_r;
    logic [7:0] rdata_r;
    logic sout_r, dout_r, doe_r, tx_irq_r, rx_irq_r;

    du_tick_if txt ();
    du_tick_if rxt ();

    du_bit_timer u_tx_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tb(txt)
    );
    du_bit_timer u_rx_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tb(rxt)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire logic wr_buf = bus_wr & (bus_addr == du_pkg::ADDR_BUF);
    wire logic wr_con = bus_wr & (bus_addr == du_pkg::ADDR_CON);
    wire logic wr_stat = bus_wr & (bus_addr == du_pkg::ADDR_STAT);
    wire logic wr_clk = bus_wr & (bus_addr == du_pkg::ADDR_CLK);
    wire logic m0 = (mode_r == du_pkg::MODE_SHIFT);
    wire logic m1 = (mode_r == du_pkg::MODE_8BIT);
    wire logic m2 = (mode_r == du_pkg::MODE_9FIX);
    wire logic tx_busy = (tx_st_r == du_pkg::ST_RUN);
    wire logic rx_busy = (rx_st_r == du_pkg::ST_RUN);
    wire logic rx_in = sync2_r;

    // ------------------------------------------------------------------
    // baud ticks
    // ------------------------------------------------------------------
    // mode 0 ticks every cycle and mode 2 every other, giving osc/16 and
    // osc/32 bits; the timer overflow is the 16x tick for modes 1 and 3
    wire logic div_tick = (div_r == du_pkg::M2_DIV_LAST);
    wire logic tx_tmr = tx_sel_r ? timer2_ovf : timer1_ovf;
    wire logic rx_tmr = rx_sel_r ? timer2_ovf : timer1_ovf;
    assign txt.tick = m0 | (m2 ? div_tick : tx_tmr);
    assign rxt.tick = m0 | (m2 ? div_tick : rx_tmr);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    wire logic [3:0] tx_last = m0 ? du_pkg::LAST_M0 : (m1 ? du_pkg::LAST_M1 : du_pkg::LAST_M23);
    wire logic tx_start = wr_buf & ~tx_busy;
    wire logic tx_end = tx_busy & txt.last & (tx_idx_r == tx_last);
    wire logic [2:0] tx_dsel = 3'(tx_idx_r - 4'h1);
    wire logic tx_data = (tx_idx_r >= 4'h1) & (tx_idx_r <= 4'h8);
    // the ninth bit is read live so software must set it in time
    wire logic tx_bit = m0 ? tx_byte_r[tx_idx_r[2:0]] :
        (tx_idx_r == 4'h0) ? 1'b0 :
        tx_data ? tx_byte_r[tx_dsel] :
        (tx_idx_r == du_pkg::NINTH_IDX && !m1) ? tb8_r :
        1'b1;
    assign txt.restart = tx_start;

    // a queued byte is taken at the end of the stop bit, so no idle bit
    // is ever inserted between frames
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_r <= du_pkg::ST_IDLE;
            tx_idx_r <= 4'h0;
            tx_byte_r <= 8'h00;
            hold_r <= 8'h00;
            hold_full_r <= 1'b0;
        end else begin
            if (tx_start) begin
                tx_st_r <= du_pkg::ST_RUN;
                tx_byte_r <= bus_wdata;
                tx_idx_r <= 4'h0;
            end else if (tx_end && (hold_full_r || wr_buf)) begin
                // a write in the very cycle the shifter empties goes straight in unless a byte is already held
                tx_byte_r <= hold_full_r ? hold_r : bus_wdata;
                hold_full_r <= 1'b0;
                tx_idx_r <= 4'h0;
            end else if (tx_end) begin
                tx_st_r <= du_pkg::ST_IDLE;
            end else if (tx_busy && txt.last) begin
                tx_idx_r <= tx_idx_r + 4'h1;
            end
            // a write while busy fills the holding slot unless the shifter empties with none held,
            // even the cycle the previous held byte moves into the shifter
            if (wr_buf && tx_busy && (hold_full_r || !tx_end)) begin
                hold_r <= bus_wdata;
                hold_full_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    wire logic [3:0] rx_last = m0 ? du_pkg::LAST_M0 : (m1 ? du_pkg::LAST_M1 : du_pkg::LAST_M23);
    wire logic rx_start = ~rx_busy & ren_r &
        (m0 ? (~ri_r & ~tx_busy) : ~rx_in);
    wire logic rx_mid = rx_busy & rxt.mid;
    wire logic rx_false = rx_mid & ~m0 & (rx_idx_r == 4'h0) & rx_in;
    wire logic rx_done = m0 ? (rx_busy & rxt.last & (rx_idx_r == du_pkg::LAST_M0)) :
        (rx_mid & (rx_idx_r == rx_last));
    wire logic [2:0] rx_dsel = 3'(rx_idx_r - 4'h1);
    wire logic rx_data = (rx_idx_r >= 4'h1) & (rx_idx_r <= 4'h8);
    wire logic stop_bit = m0 | rx_in;
    wire logic rx_load = rx_done & ~ri_r;
    wire logic brk_ev = rx_done & ~m0 & (rx_sh_r == 8'h00) & ~stop_bit &
        (m1 | ~rx_nine_r);
    wire logic fe_ev = rx_done & ~stop_bit;
    wire logic oe_ev = rx_done & ri_r;
    assign rxt.restart = rx_start;

    // samples are taken at the bit middle; in mode 0 the port itself
    // makes the shift clock so the last bit runs to its end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_r <= du_pkg::ST_IDLE;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_nine_r <= 1'b0;
            rx_buf_r <= 8'h00;
        end else begin
            if (rx_start) begin
                rx_st_r <= du_pkg::ST_RUN;
                rx_idx_r <= 4'h0;
            end else if (rx_false || rx_done) begin
                rx_st_r <= du_pkg::ST_IDLE;
            end else if (rx_busy && rxt.last) begin
                rx_idx_r <= rx_idx_r + 4'h1;
            end
            if (rx_mid && m0) begin
                rx_sh_r[rx_idx_r[2:0]] <= rx_in;
            end else if (rx_mid && rx_data) begin
                rx_sh_r[rx_dsel] <= rx_in;
            end else if (rx_mid && rx_idx_r == du_pkg::NINTH_IDX) begin
                rx_nine_r <= rx_in;
            end
            // the old character is kept when the flag is still up
            if (rx_load) begin
                rx_buf_r <= rx_sh_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // control and status registers
    // ------------------------------------------------------------------
    wire logic ti_set = tx_start | tx_end;
    wire logic rb8_new = m1 ? stop_bit : rx_nine_r;
    // hardware set wins over a software clear in the same cycle
    wire logic ti_nxt = ti_set | (wr_con ? bus_wdata[du_pkg::CON_TI] : ti_r);
    wire logic ri_nxt = rx_load | (wr_con ? bus_wdata[du_pkg::CON_RI] : ri_r);
    wire logic fe_nxt = fe_ev | (wr_stat ? bus_wdata[du_pkg::STAT_FE] : fe_r);
    wire logic br_nxt = brk_ev | (wr_stat ? bus_wdata[du_pkg::STAT_BR] : br_r);
    wire logic oe_nxt = oe_ev | (wr_stat ? bus_wdata[du_pkg::STAT_OE] : oe_r);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {mode_r, ren_r, tb8_r} <= {du_pkg::CON_RST[7:6], du_pkg::CON_RST[4:3]};
            {rb8_r, ti_r, ri_r} <= du_pkg::CON_RST[2:0];
            {fe_r, br_r, oe_r, stint_r} <= du_pkg::STAT_RST[3:0];
            {rx_sel_r, tx_sel_r} <= du_pkg::CLK_RST;
        end else begin
            if (wr_con) begin
                mode_r <= bus_wdata[du_pkg::CON_MODE+:2];
                ren_r <= bus_wdata[du_pkg::CON_REN];
                tb8_r <= bus_wdata[du_pkg::CON_TB8];
            end
            if (rx_load && !m0) begin
                rb8_r <= rb8_new;
            end else if (wr_con) begin
                rb8_r <= bus_wdata[du_pkg::CON_RB8];
            end
            ti_r <= ti_nxt;
            ri_r <= ri_nxt;
            fe_r <= fe_nxt;
            br_r <= br_nxt;
            oe_r <= oe_nxt;
            if (wr_stat) begin
                stint_r <= bus_wdata[du_pkg::STAT_STINT];
            end
            if (wr_clk) begin
                rx_sel_r <= bus_wdata[du_pkg::CLK_RX];
                tx_sel_r <= bus_wdata[du_pkg::CLK_TX];
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // buffer reads return the receive side, never the transmit byte
    wire logic [7:0] con_rd = {mode_r, 1'b0, ren_r, tb8_r, rb8_r, ti_r, ri_r};
    wire logic [7:0] stat_rd = {4'h0, fe_r, br_r, oe_r, stint_r};
    wire logic [7:0] clk_rd = {6'h00, rx_sel_r, tx_sel_r};
    wire logic [7:0] rd_mux = (bus_addr == du_pkg::ADDR_BUF) ? rx_buf_r :
        (bus_addr == du_pkg::ADDR_CON) ? con_rd :
        (bus_addr == du_pkg::ADDR_STAT) ? stat_rd :
        (bus_addr == du_pkg::ADDR_CLK) ? clk_rd : 8'h00;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= bus_rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // pins and interrupt lines
    // ------------------------------------------------------------------
    // in mode 0 the output pin carries the shift clock, low in the first
    // half of each bit so the far end latches on the rising edge
    wire logic m0_clk = m0 & (tx_busy ? 1'b1 : rx_busy);
    wire logic m0_hi = tx_busy ? txt.hi : rxt.hi;
    wire logic sout_nxt = m0_clk ? m0_hi : (tx_busy ? tx_bit : 1'b1);
    wire logic rx_irq_nxt = ri_r | (stint_r & (fe_r | br_r | oe_r));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sout_r <= 1'b1;
            dout_r <= 1'b1;
            doe_r <= 1'b0;
            tx_irq_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end else begin
            sync1_r <= serial_in_pin;
            sync2_r <= sync1_r;
            sout_r <= sout_nxt;
            dout_r <= ~(m0 & tx_busy) | tx_bit;
            doe_r <= m0 & tx_busy;
            tx_irq_r <= ti_r;
            rx_irq_r <= rx_irq_nxt;
        end
    end

    assign bus_rdata = rdata_r;
    assign serial_out_pin = sout_r;
    assign serial_in_pin_out = dout_r;
    assign serial_in_pin_oe = doe_r;
    assign tx_irq = tx_irq_r;
    assign rx_irq = rx_irq_r;
endmodule

// ==== hdl/du_pkg.sv ====
// du_pkg: register map, field positions, reset values, counts and state
// encodings for one serial port.
// assumes: a single 100 MHz clock that also stands for the oscillator.
package du_pkg;
    // ------------------------------------------------------------------
    // register offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_BUF = 3'h0;   // serial_buffer_reg
    localparam logic [2:0] ADDR_CON = 3'h1;   // serial_control_reg
    localparam logic [2:0] ADDR_STAT = 3'h2;  // serial_ext_status_reg
    localparam logic [2:0] ADDR_CLK = 3'h3;   // baud source selects
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CON_MODE = 6;   // two bits, [7:6]
    localparam int CON_REN = 4;
    localparam int CON_TB8 = 3;
    localparam int CON_RB8 = 2;
    localparam int CON_TI = 1;
    localparam int CON_RI = 0;
    localparam int STAT_FE = 3;
    localparam int STAT_BR = 2;
    localparam int STAT_OE = 1;
    localparam int STAT_STINT = 0;
    localparam int CLK_RX = 1;
    localparam int CLK_TX = 0;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CON_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [1:0] CLK_RST = 2'h0;    // timer 1 feeds both ways
    // ------------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------------
    localparam logic [3:0] SAMPLE_PT = 4'h7;  // mid point of a 16x bit
    localparam logic [3:0] LAST_PT = 4'hf;    // last 16x tick of a bit
    localparam logic M2_DIV_LAST = 1'h1;      // osc/2 ticks, x16 = osc/32
    localparam logic [3:0] LAST_M0 = 4'h7;    // eight data bits
    localparam logic [3:0] LAST_M1 = 4'h9;    // start, 8 data, stop
    localparam logic [3:0] LAST_M23 = 4'ha;   // start, 8 data, ninth, stop
    localparam logic [3:0] NINTH_IDX = 4'h9;
    // ------------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8BIT = 2'b01,
        MODE_9FIX = 2'b10,
        MODE_9VAR = 2'b11
    } du_mode_t;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } du_state_t;
endpackage

// ==== hdl/du_tick_if.sv ====
// du_tick_if: ties a 16x bit timer to the engine that it paces.
// assumes: tick and restart come from logic on sys_clk.
`timescale 1ns/10ps
interface du_tick_if;
    logic tick;     // one 16x baud tick
    logic restart;  // align the bit to count zero
    logic mid;      // sample point pulse
    logic last;     // end of bit pulse
    logic hi;       // second half of the bit
    modport timer (input tick, input restart, output mid, output last, output hi);
    modport user (output tick, output restart, input mid, input last, input hi);
endinterface

// ==== hdl/du_bit_timer.sv ====
// du_bit_timer: divides 16x ticks into bit periods with a mid pulse.
// assumes: tick is a one-cycle enable on sys_clk.
`timescale 1ns/10ps
module du_bit_timer (
    input wire logic sys_clk,
    input wire logic reset_n,
    du_tick_if.timer tb
);
    logic [3:0] cnt_r;

    // restart wins so a start edge always lands on count zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 4'h0;
        end else if (tb.restart) begin
            cnt_r <= 4'h0;
        end else if (tb.tick) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // pulses are gated by tick so they last exactly one cycle
    assign tb.mid = tb.tick & ~tb.restart & (cnt_r == du_pkg::SAMPLE_PT);
    assign tb.last = tb.tick & ~tb.restart & (cnt_r == du_pkg::LAST_PT);
    assign tb.hi = cnt_r[3];
endmodule

// ==== dv/du_uart_checker.sv ====
// du_uart_checker: port level assertions for one serial port.
// assumes: bound to du_uart; a single clock and an async active low reset.
`timescale 1ns/10ps
module du_uart_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic serial_in_pin,
    input wire logic serial_in_pin_out,
    input wire logic serial_in_pin_oe,
    input wire logic serial_out_pin,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    // ----------------------------------------------------------------
    // assertions, all in the sys_clk domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (bus_rd && bus_addr[2] |=>
        bus_rdata == 8'h00) else $error("unmapped read returned data");
    a_con_spare: assert property (bus_rd && bus_addr == du_pkg::ADDR_CON |=>
        !bus_rdata[5]) else $error("control spare bit reads one");
    a_stat_upper: assert property (bus_rd && bus_addr == du_pkg::ADDR_STAT |=>
        bus_rdata[7:4] == 4'h0) else $error("status upper bits not zero");
    a_clk_upper: assert property (bus_rd && bus_addr == du_pkg::ADDR_CLK |=>
        bus_rdata[7:2] == 6'h00) else $error("clock select upper bits not zero");
    // shift clock of mode 0: eight cycles low, eight high per bit
    a_shift_low: assert property ($fell(serial_out_pin) && serial_in_pin_oe |->
        (!serial_out_pin)[*8] ##1 serial_out_pin) else $error("shift clock low phase wrong");
    a_shift_high: assert property ($rose(serial_out_pin) && serial_in_pin_oe |->
        serial_out_pin[*8]) else $error("shift clock high phase too short");
    // flags only drop after a software write two edges before
    a_tx_sticky: assert property ($fell(tx_irq) |-> $past(bus_wr &&
        bus_addr == du_pkg::ADDR_CON && !bus_wdata[du_pkg::CON_TI], 2))
        else $error("tx interrupt dropped without a clear");
    a_rx_sticky: assert property ($fell(rx_irq) |-> $past(bus_wr &&
        (bus_addr == du_pkg::ADDR_CON || bus_addr == du_pkg::ADDR_STAT), 2))
        else $error("rx interrupt dropped without a clear");
endmodule
bind du_uart du_uart_checker chk (.sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .serial_in_pin(serial_in_pin),
    .serial_in_pin_out(serial_in_pin_out), .serial_in_pin_oe(serial_in_pin_oe),
    .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));

// ==== dv/du_peer.sv ====
// du_peer: serial peer that sends frames on the receive line.
// assumes: the line has a pull-up, so it rests high between frames.
`timescale 1ns/10ps
module du_peer (
    input wire logic sys_clk,
    output logic line
);
    initial line = 1'b1;
    // bits go out lsb first, each held per cycles; the caller builds start,
    // data, ninth and stop bits, or an all-zero break
    task automatic send(input logic [10:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            line <= bits[i];
            repeat (per) @(posedge sys_clk);
        end
        line <= 1'b1;
    endtask
endmodule

// ==== dv/dual_uart_double_buffered_tx_bench.sv ====
// dual_uart_double_buffered_tx_bench: random and corner stimulus for one port.
// assumes: du_peer drives the receive line; timers are plain pulse makers.
`timescale 1ns/10ps
module dual_uart_double_buffered_tx_bench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] bus_addr = 3'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic timer1_ovf = 1'b0;
    logic timer2_ovf = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [7:0] bus_rdata, v, d0, d1;
    logic pin_out, pin_oe, serial_out_pin, tx_irq, rx_irq, peer_line, rx_wire, b9;
    logic [21:0] got;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int n, per;
    always #5 sys_clk = ~sys_clk;
    // the shared pin: the port drives it only in mode 0 transmit
    assign rx_wire = pin_oe ? pin_out : peer_line;
    du_uart dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .serial_in_pin(rx_wire),
        .serial_in_pin_out(pin_out), .serial_in_pin_oe(pin_oe),
        .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
    du_peer peer (.sys_clk(sys_clk), .line(peer_line));
    // timer 1 overflows every 2 cycles, timer 2 every 4; a hang ends the run
    always @(posedge sys_clk) begin
        tcnt <= tcnt + 2'h1;
        timer1_ovf <= tcnt[0];
        timer2_ovf <= (tcnt == 2'h3);
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [21:0] g, input logic [21:0] e, input string what);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= x;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 x = bus_rdata;
    endtask
    task automatic wait_pin(input logic lv);
        int k;
        k = 0;
        while (serial_out_pin !== lv && k < 4000) begin
            @(posedge sys_clk);
            k++;
        end
    endtask
    // samples n bits of the transmit line at mid bit from the first start
    task automatic grab(input int nb, input int p, output logic [21:0] bits);
        bits = '0;
        wait_pin(1'b0);
        repeat (p / 2) @(posedge sys_clk);
        for (int i = 0; i < nb; i++) begin
            bits[i] = serial_out_pin;
            repeat (p) @(posedge sys_clk);
        end
    endtask
    function automatic logic [7:0] con(input int m, input logic ren, input logic tb8);
        con = {m[1:0], 1'b0, ren, tb8, 3'b000};
    endfunction
    // frame lsb first: start, data, ninth bit in modes 2 and 3, stop
    function automatic logic [10:0] frame(input int m, input logic [7:0] x, input logic t9);
        frame = (m == 1) ? {2'b01, x, 1'b0} : {1'b1, t9, x, 1'b0};
    endfunction
    initial begin
        void'($urandom(69));
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 1; a < 4; a++) begin
            rd(3'(a), v);
            check(v, 8'h00, "reset value");
        end
        wr(3'h5, 8'hff);
        rd(3'h5, v);
        check(v, 8'h00, "unmapped read");
        $display("test registers done");
        // two bytes back to back; ninth bit is changed after the first write
        for (int m = 1; m < 4; m++) begin
            n = (m == 1) ? 10 : 11;
            per = (m == 3) ? 64 : 32;
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            b9 = 1'($urandom);
            wr(du_pkg::ADDR_CLK, (m == 3) ? 8'h01 : 8'h00);
            wr(du_pkg::ADDR_CON, con(m, 1'b0, ~b9));
            fork
                grab(2 * n, per, got);
                begin
                    wr(du_pkg::ADDR_BUF, d0);
                    rd(du_pkg::ADDR_CON, v);
                    check(v, con(m, 1'b0, ~b9) | 8'h02, "done on idle write");
                    wr(du_pkg::ADDR_CON, con(m, 1'b0, b9));
                    wr(du_pkg::ADDR_BUF, d1);
                end
            join
            check(got, (22'(frame(m, d1, b9)) << n) | 22'(frame(m, d0, b9)),
                "frames");
            rd(du_pkg::ADDR_CON, v);
            check(v[1], 1'b1, "done after stop");
            check({tx_irq, rx_irq}, 2'b10, "irq lines");
            wr(du_pkg::ADDR_CON, 8'h00);
        end
        $display("test transmit done");
        // receive: refused while disabled, then data, overrun and break
        for (int m = 1; m < 4; m++) begin
            n = (m == 1) ? 10 : 11;
            per = (m == 3) ? 64 : 32;
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            b9 = 1'($urandom);
            wr(du_pkg::ADDR_CLK, (m == 3) ? 8'h02 : 8'h00);
            // same mode as below, so only the enable bit refuses the frame
            wr(du_pkg::ADDR_CON, con(m, 1'b0, 1'b0));
            peer.send(frame(m, d1, b9), n, per);
            rd(du_pkg::ADDR_CON, v);
            check(v[0], 1'b0, "receive while disabled");
            wr(du_pkg::ADDR_CON, con(m, 1'b1, 1'b0));
            peer.send(frame(m, d0, b9), n, per);
            rd(du_pkg::ADDR_CON, v);
            check(v[2:0], {(m == 1) ? 1'b1 : b9, 2'b01},
                "rx flags");
            check(rx_irq, 1'b1, "rx irq");
            peer.send(frame(m, d1, ~b9), n, per);
            rd(du_pkg::ADDR_STAT, v);
            check(v, 8'h02, "overrun");
            rd(du_pkg::ADDR_BUF, v);
            check(v, d0, "buffer kept");
            wr(du_pkg::ADDR_STAT, 8'h00);
            wr(du_pkg::ADDR_CON, con(m, 1'b1, 1'b0));
            peer.send(11'h000, n, per);
            rd(du_pkg::ADDR_STAT, v);
            check(v, 8'h0c, "break and framing");
            // the low tail of the break may start one more frame; let it end
            repeat ((n + 1) * per) @(posedge sys_clk);
            wr(du_pkg::ADDR_STAT, 8'h00);
            wr(du_pkg::ADDR_CON, 8'h00);
        end
        $display("test receive done");
        // mode 0: data on the shared pin, taken at each shift clock rise
        d0 = 8'($urandom);
        fork
            begin
                wr(du_pkg::ADDR_BUF, d0);
                wr(du_pkg::ADDR_CON, 8'h00);
            end
            for (int i = 0; i < 8; i++) begin
                wait_pin(1'b0);
                wait_pin(1'b1);
                got[i] = pin_out;
                check(pin_oe, 1'b1, "mode 0 drive");
            end
        join
        check(got[7:0], d0, "mode 0 byte");
        // the eighth bit ends half a bit after its clock rise
        repeat (16) @(posedge sys_clk);
        rd(du_pkg::ADDR_CON, v);
        check(v[1], 1'b1, "mode 0 done");
        // enabling with rx complete clear starts the shift clock at once
        d1 = 8'($urandom);
        wr(du_pkg::ADDR_CON, con(0, 1'b1, 1'b0));
        peer.send({3'h7, d1}, 8, 16);
        rd(du_pkg::ADDR_CON, v);
        check(v[0], 1'b1, "mode 0 receive");
        rd(du_pkg::ADDR_BUF, v);
        check(v, d1, "mode 0 rx byte");
        $display("test shift mode done");
        end_sim();
    end
endmodule
